/* File: rtl/lin_xcvr_pkg.sv */
// Package for the transceiver mode and wake-up control logic.
// Assumes a single 100 MHz system clock; all times become cycle counts here.
package lin_xcvr_pkg;

   // ****************************************
   // Clock rate
   // ****************************************
   localparam int CLK_MHZ = 100;

   // ****************************************
   // Timing figures in their own units
   // ****************************************
   localparam int T_DOM_MS = 6;          // Dominant time-out, least
   localparam int T_TXD_HIGH_US = 10;    // Recessive hold to clear time-out
   localparam int T_BUS_US = 30;         // Bus wake debounce, least
   localparam int T_WAKE_US = 7;         // Local wake debounce, least
   localparam int T_WAKE_REARM_US = 6;   // Local wake high re-arm time
   localparam int T_NORM_US = 2;         // Pre-normal to normal delay, least
   localparam int T_SLEEP_US = 2;        // Normal to sleep delay, least

   // ****************************************
   // Derived cycle counts (time-out, clear and re-arm counts are whole cycles plus one)
   // ****************************************
   localparam int DOM_CYC = T_DOM_MS * 1000 * CLK_MHZ + 1;
   localparam int TXD_HIGH_CYC = T_TXD_HIGH_US * CLK_MHZ + 1;
   localparam int BUS_CYC = T_BUS_US * CLK_MHZ;
   localparam int WAKE_CYC = T_WAKE_US * CLK_MHZ;
   localparam int REARM_CYC = T_WAKE_REARM_US * CLK_MHZ + 1;
   localparam int NORM_CYC = T_NORM_US * CLK_MHZ;
   localparam int SLEEP_CYC = T_SLEEP_US * CLK_MHZ;

   localparam int CNT_W = 20;

   // ****************************************
   // Operating modes
   // ****************************************
   typedef enum logic [1:0] {
      MODE_PRENORMAL = 2'b00,
      MODE_NORMAL = 2'b01,
      MODE_SLEEP = 2'b10
   } lin_mode_t;

   typedef enum logic [1:0] {
      SRC_NONE = 2'b00,
      SRC_REMOTE = 2'b01,
      SRC_LOCAL = 2'b10
   } wake_src_t;

endpackage

/* File: rtl/lin_wake_if.sv */
// Interface carrying wake-up events from the detectors and their arming from the controller.
// Assumes one system clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none
interface lin_wake_if;
   logic arm;        // Detectors raise wake pulses only while asleep
   logic remote_req; // One-cycle remote wake pulse
   logic local_req;  // One-cycle local wake pulse
   modport ctrl (output arm, input remote_req, input local_req);
   modport det (input arm, output remote_req, output local_req);
endinterface
`default_nettype wire

/* File: rtl/lin_wake_detect.sv */
// Remote and local wake-up detectors with debounce.
// Assumes synchronous inputs; arm is high only in sleep mode.
`timescale 1ns/1ns
`default_nettype none
module lin_wake_detect
   import lin_xcvr_pkg::*;
#(
   parameter int BUS_TC = BUS_CYC,
   parameter int WAKE_TC = WAKE_CYC,
   parameter int REARM_TC = REARM_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_lin_rx,
   input wire logic i_wake,
   lin_wake_if.det wk
);

   logic [CNT_W-1:0] bus_cnt_q;
   logic bus_ok_q;
   logic lin_prev_q;
   logic [CNT_W-1:0] loc_cnt_q;
   logic [CNT_W-1:0] hi_cnt_q;
   logic loc_armed_q;
   logic loc_done_q;
   logic wake_prev_q;
   logic remote_q;
   logic local_q;

   assign wk.remote_req = remote_q;
   assign wk.local_req = local_q;

   // ****************************************
   // Remote wake: fall, dominant for debounce, rise
   // ****************************************
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bus_cnt_q <= '0;
         bus_ok_q <= 1'b0;
         lin_prev_q <= 1'b1;
         remote_q <= 1'b0;
      end else begin
         lin_prev_q <= i_lin_rx;
         remote_q <= 1'b0;
         if (!wk.arm) begin
            bus_cnt_q <= '0;
            bus_ok_q <= 1'b0;
         end else if (lin_prev_q && !i_lin_rx) begin
            // Only a fresh falling edge starts timing; a bus stuck low never wakes
            bus_cnt_q <= CNT_W'(1);
            bus_ok_q <= 1'b0;
         end else if (!i_lin_rx && bus_cnt_q != '0) begin
            if (bus_cnt_q >= CNT_W'(BUS_TC)) bus_ok_q <= 1'b1; // [R12] [R23]
            else bus_cnt_q <= bus_cnt_q + CNT_W'(1);
         end else if (!lin_prev_q && i_lin_rx) begin
            remote_q <= bus_ok_q; // Rising edge completes the sequence [R12]
            bus_cnt_q <= '0;
            bus_ok_q <= 1'b0;
         end
      end
   end

   // ****************************************
   // Local wake: fall, low for debounce; re-arm after long high
   // ****************************************
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         loc_cnt_q <= '0;
         hi_cnt_q <= '0;
         loc_armed_q <= 1'b0;
         loc_done_q <= 1'b0;
         wake_prev_q <= 1'b1;
         local_q <= 1'b0;
      end else begin
         wake_prev_q <= i_wake;
         local_q <= 1'b0;
         // High time counted at all times, so re-arm needs a real high phase
         if (i_wake) begin
            if (hi_cnt_q < CNT_W'(REARM_TC)) hi_cnt_q <= hi_cnt_q + CNT_W'(1);
            else loc_armed_q <= 1'b1; // [R16]
         end else begin
            // A low phase forgets any earlier long high, so only the phase just ended re-arms
            hi_cnt_q <= '0;
            loc_armed_q <= 1'b0; // [R16] [R17]
         end
         if (!wk.arm) begin
            loc_cnt_q <= '0;
            loc_done_q <= 1'b0;
         end else if (wake_prev_q && !i_wake && loc_armed_q) begin
            loc_cnt_q <= CNT_W'(1);
            loc_armed_q <= 1'b0; // Held low from sleep entry never fires [R17]
         end else if (!i_wake && loc_cnt_q != '0 && !loc_done_q) begin
            if (loc_cnt_q >= CNT_W'(WAKE_TC)) begin
               local_q <= 1'b1; // [R14] [R24]
               loc_done_q <= 1'b1;
            end else begin
               loc_cnt_q <= loc_cnt_q + CNT_W'(1);
            end
         end else if (i_wake) begin
            loc_cnt_q <= '0;
            loc_done_q <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

/* File: rtl/lin_tx_guard.sv */
// Transmit dominant time-out guard.
// Assumes transmit input synchronous to the system clock.
`timescale 1ns/1ns
`default_nettype none
module lin_tx_guard
   import lin_xcvr_pkg::*;
#(
   parameter int DOM_TC = DOM_CYC,
   parameter int HIGH_TC = TXD_HIGH_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_txd,
   output logic o_timeout
);

   logic [CNT_W-1:0] low_cnt_q;
   logic [CNT_W-1:0] high_cnt_q;
   logic timeout_q;

   assign o_timeout = timeout_q;

   // ****************************************
   // Low time counter trips, long high clears
   // ****************************************
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         low_cnt_q <= '0;
         high_cnt_q <= '0;
         timeout_q <= 1'b0;
      end else if (!i_txd) begin
         high_cnt_q <= '0;
         if (low_cnt_q >= CNT_W'(DOM_TC)) timeout_q <= 1'b1; // [R2] [R27]
         else low_cnt_q <= low_cnt_q + CNT_W'(1);
      end else begin
         low_cnt_q <= '0;
         if (high_cnt_q >= CNT_W'(HIGH_TC)) timeout_q <= 1'b0; // [R3]
         else high_cnt_q <= high_cnt_q + CNT_W'(1);
      end
   end

endmodule
`default_nettype wire

/* File: rtl/lin_xcvr_ctrl.sv */
// Mode and wake-up control of a single-wire bus transceiver.
// Assumes all pin levels arrive already synchronous to i_clk_sys.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// [R1] Low transmit input drives bus dominant when permitted
// [R2] Long transmit low trips driver off
// [R3] High beyond ten microseconds clears time-out
// [R4] Receive output mirrors bus in normal mode
// [R5] Enable high selects normal mode, both paths; code ignores enable in sleep and reaches normal from pre-normal only
// [R6] Enable fall with transmit high enters sleep
// [R7] Inhibit on in normal, off in sleep
// [R8] Any wake event turns inhibit on
// [R9] Power-up enters pre-normal, inhibit on
// [R10] Pre-normal to normal needs enable high
// [R11] Sleep accepted whatever bus or wake level
// [R12] Remote wake: fall, debounced dominant, rise
// [R13] Remote wake: pre-normal, inhibit, termination, receive low
// [R14] Local wake: fall then debounced low
// [R15] Local wake also strongly pulls transmit pin
// [R16] Local re-arm needs six microseconds high
// [R17] Wake held low keeps device asleep
// [R18] Wake source shown on transmit pin pull
// [R19] Enable high clears wake flags immediately
// [R20] Undervoltage blocks transmission
// [R21] Over-temperature switches driver off, hysteresis external
// [R22] Sleep: no termination, weak pull-up, inhibit floats
// [R23] Bus wake debounce thirty microseconds least
// [R24] Local wake debounce seven microseconds least
// [R25] Normal entry delay two microseconds least
// [R26] Sleep entry delay two microseconds least
// [R27] All timings are counters on one clock
module lin_xcvr_ctrl
   import lin_xcvr_pkg::*;
#(
   parameter int DOM_TC = DOM_CYC,
   parameter int BUS_TC = BUS_CYC,
   parameter int WAKE_TC = WAKE_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_txd,
   input wire logic i_en,
   input wire logic i_wake,
   input wire logic i_lin_rx,
   input wire logic i_undervolt,
   input wire logic i_overtemp,
   output logic o_lin_drive,
   output logic o_rxd_drive,
   output logic o_rxd_oe,
   output logic o_txd_weak_pd,
   output logic o_txd_strong_pd,
   output logic o_regulator_inhibit_out,
   output logic o_regulator_inhibit_oe,
   output logic o_term_en,
   output logic o_weak_pullup,
   output logic [1:0] o_mode
);

   // ****************************************
   // State
   // ****************************************
   lin_mode_t mode_q;
   wake_src_t src_q, src_d;
   logic [CNT_W-1:0] dly_cnt_q;
   logic en_prev_q;
   logic sleep_pend_q;
   logic tx_timeout;
   logic tx_ok;
   lin_wake_if wk ();

   // ****************************************
   // Sub-blocks
   // ****************************************
   lin_tx_guard #(
      .DOM_TC(DOM_TC),
      .HIGH_TC(TXD_HIGH_CYC)
   ) u_guard (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_txd(i_txd),
      .o_timeout(tx_timeout)
   );

   lin_wake_detect #(
      .BUS_TC(BUS_TC),
      .WAKE_TC(WAKE_TC),
      .REARM_TC(REARM_CYC)
   ) u_wake (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_lin_rx(i_lin_rx),
      .i_wake(i_wake),
      .wk(wk)
   );

   // Detectors listen only while asleep
   assign wk.arm = (mode_q == MODE_SLEEP);

   // ****************************************
   // Mode machine
   // ****************************************
   // Reset stands for supply power-up [R9]
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_q <= MODE_PRENORMAL;
         dly_cnt_q <= '0;
         en_prev_q <= 1'b0;
         sleep_pend_q <= 1'b0;
      end else begin
         en_prev_q <= i_en;
         case (mode_q)
            MODE_PRENORMAL: begin
               sleep_pend_q <= 1'b0;
               // Enable must stay high for the whole delay [R10]
               if (!i_en) begin
                  dly_cnt_q <= '0;
               end else if (dly_cnt_q >= CNT_W'(NORM_CYC - 1)) begin
                  mode_q <= MODE_NORMAL; // [R5] [R25]
                  dly_cnt_q <= '0;
               end else begin
                  dly_cnt_q <= dly_cnt_q + CNT_W'(1);
               end
            end
            MODE_NORMAL: begin
               // Falling enable with transmit high arms sleep entry [R6]
               if (en_prev_q && !i_en && i_txd) begin
                  sleep_pend_q <= 1'b1;
                  dly_cnt_q <= '0;
               end else if (sleep_pend_q) begin
                  if (i_en) begin
                     // Glitch on enable: abandon the request
                     sleep_pend_q <= 1'b0;
                     dly_cnt_q <= '0;
                  end else if (dly_cnt_q >= CNT_W'(SLEEP_CYC - 1)) begin
                     // Bus and wake levels play no part here [R11]
                     mode_q <= MODE_SLEEP; // [R26]
                     sleep_pend_q <= 1'b0;
                     dly_cnt_q <= '0;
                  end else begin
                     dly_cnt_q <= dly_cnt_q + CNT_W'(1);
                  end
               end
            end
            MODE_SLEEP: begin
               dly_cnt_q <= '0;
               sleep_pend_q <= 1'b0;
               if (wk.remote_req || wk.local_req) begin
                  mode_q <= MODE_PRENORMAL; // [R13] [R15]
               end
            end
            default: begin
               mode_q <= MODE_PRENORMAL;
               dly_cnt_q <= '0;
               sleep_pend_q <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************
   // Wake source memory
   // ****************************************
   always_comb begin
      src_d = src_q;
      if (wk.local_req) src_d = SRC_LOCAL;
      else if (wk.remote_req) src_d = SRC_REMOTE;
      else if (i_en) src_d = SRC_NONE; // [R19]
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) src_q <= SRC_NONE;
      else src_q <= src_d;
   end

   // ****************************************
   // Pin drivers, all registered
   // ****************************************
   // Driver permitted only in normal mode, healthy supply, cool die
   assign tx_ok = (mode_q == MODE_NORMAL) && !tx_timeout
                  && !i_undervolt && !i_overtemp; // [R20] [R21]

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_lin_drive <= 1'b0;
         o_rxd_drive <= 1'b0;
         o_rxd_oe <= 1'b0;
         o_txd_weak_pd <= 1'b0;
         o_txd_strong_pd <= 1'b0;
         o_regulator_inhibit_out <= 1'b0;
         o_regulator_inhibit_oe <= 1'b0;
         o_term_en <= 1'b0;
         o_weak_pullup <= 1'b0;
         o_mode <= 2'b00;
      end else begin
         o_lin_drive <= tx_ok && !i_txd; // [R1] [R2] [R3]
         // Open drain: low in normal mode when bus dominant, in pre-normal when wake flag pending
         if (mode_q == MODE_NORMAL) begin
            o_rxd_oe <= !i_lin_rx; // [R4]
         end else begin
            o_rxd_oe <= (mode_q == MODE_PRENORMAL) && (src_d != SRC_NONE); // [R13] [R19]
         end
         o_rxd_drive <= 1'b0;
         o_txd_weak_pd <= (mode_q == MODE_PRENORMAL) && (src_d == SRC_REMOTE); // [R18]
         o_txd_strong_pd <= (mode_q == MODE_PRENORMAL) && (src_d == SRC_LOCAL); // [R15] [R18]
         // High-side switch: on outside sleep, floating in sleep
         o_regulator_inhibit_out <= (mode_q != MODE_SLEEP); // [R7] [R8] [R9]
         o_regulator_inhibit_oe <= (mode_q != MODE_SLEEP); // [R22]
         o_term_en <= (mode_q != MODE_SLEEP); // [R22]
         o_weak_pullup <= (mode_q == MODE_SLEEP); // [R22]
         o_mode <= mode_q;
      end
   end

endmodule
`default_nettype wire

/* File: testbench/lin_xcvr_props.sv */
// Checker for the transceiver mode control.
// Assumes it is bound to lin_xcvr_ctrl and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module lin_xcvr_props
   import lin_xcvr_pkg::*;
#(
   parameter int DOM_TC = DOM_CYC,
   parameter int BUS_TC = BUS_CYC,
   parameter int WAKE_TC = WAKE_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_txd,
   input wire logic i_en,
   input wire logic i_wake,
   input wire logic i_lin_rx,
   input wire logic i_undervolt,
   input wire logic i_overtemp,
   input wire logic o_lin_drive,
   input wire logic o_rxd_drive,
   input wire logic o_rxd_oe,
   input wire logic o_txd_weak_pd,
   input wire logic o_txd_strong_pd,
   input wire logic o_regulator_inhibit_out,
   input wire logic o_regulator_inhibit_oe,
   input wire logic o_term_en,
   input wire logic o_weak_pullup,
   input wire logic [1:0] o_mode
);
   // Run lengths of pin levels up to the previous edge
   logic [CNT_W-1:0] tlow_q, dom_q, enh_q, enl_q;
   // Low until the first edge after reset, while outputs still show reset values
   logic live_q;
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tlow_q <= '0;
         dom_q <= '0;
         enh_q <= '0;
         enl_q <= '0;
         live_q <= 1'b0;
      end else begin
         tlow_q <= i_txd ? '0 : tlow_q + CNT_W'(1);
         dom_q <= i_lin_rx ? '0 : dom_q + CNT_W'(1);
         enh_q <= i_en ? enh_q + CNT_W'(1) : '0;
         enl_q <= i_en ? '0 : enl_q + CNT_W'(1);
         live_q <= 1'b1;
      end
   end

   // ********************
   // Assertions
   // ********************
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);
   // Wake needs a long dominant ended by a rise while asleep
   sequence s_bus_pulse;
      o_mode == 2'h2 && $rose(i_lin_rx) && dom_q >= BUS_TC + 2;
   endsequence
   sequence s_remote_flag;
      o_mode == 2'h0 && o_rxd_oe && o_txd_weak_pd && o_term_en;
   endsequence
   a_drive_in_normal: assert property (o_lin_drive |-> o_mode == 2'h1)
      else $error("drive outside normal");
   a_txd_high_release: assert property (i_txd [*2] |=> !o_lin_drive)
      else $error("drive with transmit high");
   a_undervolt_blocks: assert property (i_undervolt [*2] |=> !o_lin_drive)
      else $error("drive under undervoltage");
   a_overtemp_off: assert property (i_overtemp [*2] |=> !o_lin_drive)
      else $error("drive while hot");
   a_dom_timeout: assert property (tlow_q > DOM_TC + 2 |-> !o_lin_drive)
      else $error("dominant time-out missed");
   a_inhibit_when_awake: assert property ((live_q && o_mode != 2'h2) |-> o_regulator_inhibit_out && o_regulator_inhibit_oe)
      else $error("inhibit off while awake");
   a_sleep_pins: assert property (o_mode == 2'h2 |-> !o_regulator_inhibit_oe && !o_term_en && o_weak_pullup)
      else $error("sleep pin state wrong");
   a_rx_mirror: assert property ((o_mode == 2'h1 && $past(o_mode) == 2'h1) |-> !o_rxd_drive && (o_rxd_oe == !$past(i_lin_rx)))
      else $error("receive pin not following bus");
   a_en_clears_flags: assert property ((o_mode == 2'h0 && $past(i_en)) |-> !(o_rxd_oe || o_txd_weak_pd || o_txd_strong_pd))
      else $error("wake flags kept after enable");
   a_norm_delay: assert property ((o_mode == 2'h1 && $past(o_mode) == 2'h0) |-> enh_q >= NORM_CYC)
      else $error("normal entered too early");
   a_sleep_delay: assert property ((o_mode == 2'h2 && $past(o_mode) == 2'h1) |-> enl_q >= SLEEP_CYC)
      else $error("sleep entered too early");
   a_remote_wake: assert property (s_bus_pulse |-> ##[1:4] s_remote_flag)
      else $error("remote wake not taken");
endmodule
bind lin_xcvr_ctrl lin_xcvr_props #(.DOM_TC(DOM_TC), .BUS_TC(BUS_TC), .WAKE_TC(WAKE_TC))
   u_props (.*);
`default_nettype wire

/* File: testbench/lin_bus_model.sv */
// Far side: wired bus with pull-up, receive pin pull-up, controller transmit pin.
// Assumes level inputs; it has no timing of its own.
`timescale 1ns/1ns
`default_nettype none
module lin_bus_model (
   input wire logic i_lin_drive,
   input wire logic i_other_dom,
   input wire logic i_rxd_oe,
   input wire logic i_uc_txd_oe,
   input wire logic i_uc_txd,
   input wire logic i_txd_strong_pd,
   output logic o_lin,
   output logic o_rxd,
   output logic o_txd
);
   // Any node pulls the bus dominant, else recessive
   assign o_lin = !(i_lin_drive || i_other_dom);
   // Open drain receive pin
   assign o_rxd = !i_rxd_oe;
   // Released pin: pull-up beats weak pull, strong pull wins
   assign o_txd = i_uc_txd_oe ? i_uc_txd : !i_txd_strong_pd;
endmodule
`default_nettype wire

/* File: testbench/lin_xcvr_ctrl_bench.sv */
// Bench for the transceiver mode control, with bus and pin model.
// Assumes shortened time-out and debounce counts.
`timescale 1ns/1ns
`default_nettype none
module lin_xcvr_ctrl_bench;
   import lin_xcvr_pkg::*;
   localparam int DOM_T = 50;
   localparam int BUS_T = 20;
   localparam int WAKE_T = 10;
   logic i_clk_sys, i_rst_n, i_txd, i_en, i_wake, i_lin_rx, i_undervolt, i_overtemp;
   logic o_lin_drive, o_rxd_drive, o_rxd_oe, o_txd_weak_pd, o_txd_strong_pd, o_term_en;
   logic o_regulator_inhibit_out, o_regulator_inhibit_oe, o_weak_pullup;
   logic [1:0] o_mode;
   logic uc_txd, uc_oe, far_dom, rxd_pin;
   int fail_count, checked;
   wire logic [2:0] awake = {o_regulator_inhibit_out, o_regulator_inhibit_oe, o_term_en};
   lin_xcvr_ctrl #(.DOM_TC(DOM_T), .BUS_TC(BUS_T), .WAKE_TC(WAKE_T)) dut (.*);
   lin_bus_model bus (.i_lin_drive(o_lin_drive), .i_other_dom(far_dom), .i_rxd_oe(o_rxd_oe),
      .i_uc_txd_oe(uc_oe), .i_uc_txd(uc_txd), .i_txd_strong_pd(o_txd_strong_pd),
      .o_lin(i_lin_rx), .o_rxd(rxd_pin), .o_txd(i_txd));
   // 100 MHz clock
   initial begin
      i_clk_sys = 1'h0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   // Inputs move at falling edges only
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ********************
   // Scenarios
   // ********************
   // Reset stands for supply power-up; low transmit must not drive yet
   task automatic power_up;
      i_en = 1'h0;
      uc_txd = 1'h0;
      i_rst_n = 1'h0;
      cyc(20);
      i_rst_n = 1'h1;
      cyc(50);
      check("pre", {o_mode, awake, o_lin_drive}, 6'h0e);
      uc_txd = 1'h1;
   endtask
   // Controller confirms normal mode
   task automatic go_normal;
      uc_oe = 1'h1;
      i_en = 1'h1;
      cyc(2);
      check("flags", {o_rxd_oe, o_txd_weak_pd, o_txd_strong_pd}, 3'h0);
      cyc(150);
      check("norm early", o_mode, 2'h0);
      cyc(80);
      check("norm", {o_mode, awake}, 5'h0f);
   endtask
   // Both paths, then supply and thermal blocking
   task automatic tx_rx;
      uc_txd = 1'h0;
      cyc(3);
      check("dom", {o_lin_drive, i_lin_rx, rxd_pin}, 3'h4);
      uc_txd = 1'h1;
      far_dom = 1'h1;
      cyc(3);
      check("far dom", {o_lin_drive, rxd_pin}, 2'h0);
      far_dom = 1'h0;
      uc_txd = 1'h0;
      i_undervolt = 1'h1;
      cyc(3);
      check("undervolt", o_lin_drive, 1'h0);
      i_undervolt = 1'h0;
      i_overtemp = 1'h1;
      cyc(3);
      check("hot", o_lin_drive, 1'h0);
      i_overtemp = 1'h0;
      cyc(3);
      check("cool", o_lin_drive, 1'h1);
      uc_txd = 1'h1;
   endtask
   // Stuck low trips; a short high does not clear it
   task automatic dom_timeout;
      uc_txd = 1'h0;
      cyc(DOM_T + 10);
      check("tripped", o_lin_drive, 1'h0);
      uc_txd = 1'h1;
      cyc(500);
      uc_txd = 1'h0;
      cyc(3);
      check("short high", o_lin_drive, 1'h0);
      uc_txd = 1'h1;
      cyc(TXD_HIGH_CYC + 10);
      uc_txd = 1'h0;
      cyc(3);
      check("cleared", o_lin_drive, 1'h1);
      uc_txd = 1'h1;
   endtask
   // Sleep request; with refuse set, a first try with transmit low must be ignored
   task automatic enter_sleep(input bit refuse);
      if (refuse) begin
         uc_txd = 1'h0;
         i_en = 1'h0;
         cyc(300);
         check("refused", o_mode, 2'h1);
         i_en = 1'h1;
         uc_txd = 1'h1;
         cyc(TXD_HIGH_CYC + 10);
      end
      i_en = 1'h0;
      cyc(150);
      check("sleep early", o_mode, 2'h1);
      cyc(80);
      check("sleep", {o_mode, awake[1:0], o_weak_pullup}, 5'h11);
   endtask
   // Short pulse filtered; long one wakes on its rise
   task automatic remote_wake;
      uc_oe = 1'h0;
      far_dom = 1'h1;
      cyc(BUS_T / 2);
      far_dom = 1'h0;
      cyc(20);
      check("short pulse", o_mode, 2'h2);
      far_dom = 1'h1;
      cyc(BUS_T + 10);
      check("held dom", o_mode, 2'h2);
      far_dom = 1'h0;
      cyc(6);
      check("remote", {o_mode, awake, rxd_pin}, 6'h0e);
      check("src", {o_txd_weak_pd, o_txd_strong_pd, i_txd}, 3'h5);
   endtask
   // Wake low and bus dominant through sleep entry; short high must not re-arm
   task automatic local_wake;
      i_wake = 1'h0;
      far_dom = 1'h1;
      enter_sleep(1'h0);
      cyc(2000);
      check("stay asleep", o_mode, 2'h2);
      i_wake = 1'h1;
      cyc(300);
      i_wake = 1'h0;
      cyc(WAKE_T + 20);
      check("no rearm", o_mode, 2'h2);
      i_wake = 1'h1;
      cyc(REARM_CYC + 20);
      i_wake = 1'h0;
      cyc(WAKE_T - 4);
      check("filtering", o_mode, 2'h2);
      uc_oe = 1'h0;
      cyc(12);
      check("local", {o_mode, awake, rxd_pin}, 6'h0e);
      check("src", {o_txd_weak_pd, o_txd_strong_pd, i_txd}, 3'h2);
      far_dom = 1'h0;
      i_wake = 1'h1;
   endtask
   // Main sequence; the last power-up is a second reset mid-run
   initial begin
      i_rst_n = 1'h0;
      i_en = 1'h0;
      i_wake = 1'h1;
      i_undervolt = 1'h0;
      i_overtemp = 1'h0;
      uc_txd = 1'h1;
      uc_oe = 1'h1;
      far_dom = 1'h0;
      fail_count = 0;
      checked = 0;
      power_up;
      go_normal;
      tx_rx;
      dom_timeout;
      enter_sleep(1'h1);
      remote_wake;
      go_normal;
      local_wake;
      go_normal;
      power_up;
      tally_and_finish;
   end
endmodule
`default_nettype wire
